//--- rtl/sram_dev_end.sv
// memory device end: input capture of the write port, lane masks
// and the shared address bus, with two burst-word arrays behind it
// assumes the controller end drives the link on the same core clock;
// kEdge high marks a positive-clock edge, low the inverted-clock edge
`timescale 1ns/100ps

// What this block does
// - write select active low, positive edge
// - low select starts a write burst
// - high select ignores write data
// - nibble masks sampled both edges, x8
// - masked-off nibble keeps stored bits
// - byte masks sampled on both edges
// - mask captured with its own data word
// - masked-off byte lane left unchanged
// - read address k, write address k-bar
// - controller multiplexes the two addresses
// - two arrays, one per burst word
// - address width set per variant
// - deselected port ignores its address
// - data captured on both clock edges
module sram_dev_end #(
    parameter int ADDR_W = sram_link_pkg::ADDR_W_X36,
    parameter int DATA_W = sram_link_pkg::DATA_W_X36,
    parameter int MASK_W = sram_link_pkg::MASK_W_X36
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link
    sram_link_if.dev link,
    // write completion
    output logic wrDone,
    output logic [ADDR_W-1:0] wrDoneAddr,
    // read capture
    output logic rdValid,
    output logic [ADDR_W-1:0] rdDoneAddr,
    output logic [DATA_W-1:0] rdData0,
    output logic [DATA_W-1:0] rdData1
);
    import sram_link_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    // two lanes of four on x8
    localparam int LANE_W = DATA_W / MASK_W;

    // ==========================================================
    // lane decode
    function automatic logic laneOn(input logic [MASK_W-1:0] maskN,
                                    input int lane);
        laneOn = !maskN[lane];
    endfunction

    // ==========================================================
    // capture state
    logic wrArmed_r;
    logic [DATA_W-1:0] word0_r;
    logic [MASK_W-1:0] mask0_r;
    logic wrGo;
    logic [ADDR_W-1:0] wrAddr;
    logic rdArmed_r;
    logic [ADDR_W-1:0] rdAddr_r;
    logic rdValid_r;
    logic wrDone_r;
    logic [ADDR_W-1:0] wrDoneAddr_r;
    logic [ADDR_W-1:0] rdDoneAddr_r;
    logic [DATA_W-1:0] rdWord0;
    logic [DATA_W-1:0] rdWord1;
    logic wrSel;
    logic rdSel;

    // selects count on positive slot only
    assign wrSel = link.kEdge && !link.writePortSelectN;
    assign rdSel = link.kEdge && !link.readPortSelectN;

    // ==========================================================
    // write select sampling
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrArmed_r <= 1'b0;
        end else if (link.kEdge) begin
            wrArmed_r <= !link.writePortSelectN;
        end else begin
            wrArmed_r <= 1'b0;
        end
    end

    // ==========================================================
    // first burst word and its mask
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            word0_r <= '0;
            mask0_r <= '1;
        end else if (wrSel) begin
            word0_r <= link.data;
            mask0_r <= link.byteLaneWriteMaskN;
        end
    end

    assign wrGo = wrArmed_r && !link.kEdge;
    assign wrAddr = link.addr;

    // ==========================================================
    // write completion report
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrDone_r <= 1'b0;
            wrDoneAddr_r <= '0;
        end else begin
            wrDone_r <= wrGo;
            if (wrGo) begin
                wrDoneAddr_r <= wrAddr;
            end
        end
    end

    // ==========================================================
    // read address capture
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdArmed_r <= 1'b0;
            rdAddr_r <= '0;
        end else begin
            rdArmed_r <= rdSel;
            if (rdSel) begin
                rdAddr_r <= link.addr;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdValid_r <= 1'b0;
            rdDoneAddr_r <= '0;
        end else begin
            rdValid_r <= rdArmed_r;
            if (rdArmed_r) begin
                rdDoneAddr_r <= rdAddr_r;
            end
        end
    end

    // ==========================================================
    // storage: two arrays, split into byte or nibble lanes
    // one array per burst word
    for (genvar l = 0; l < MASK_W; l++) begin : g_lane
        logic [LANE_W-1:0] arrA [DEPTH];
        logic [LANE_W-1:0] arrB [DEPTH];
        logic [LANE_W-1:0] rdA_r;
        logic [LANE_W-1:0] rdB_r;
        logic laneWrA;
        logic laneWrB;

        assign laneWrA = wrGo && laneOn(mask0_r, l);
        assign laneWrB = wrGo && laneOn(link.byteLaneWriteMaskN, l);

        always_ff @(posedge core_clk) begin
            if (laneWrA) begin
                arrA[wrAddr] <= word0_r[l*LANE_W +: LANE_W];
            end
        end

        always_ff @(posedge core_clk) begin
            if (laneWrB) begin
                arrB[wrAddr] <= link.data[l*LANE_W +: LANE_W];
            end
        end

        always_ff @(posedge core_clk) begin
            if (rdArmed_r) begin
                rdA_r <= arrA[rdAddr_r];
                rdB_r <= arrB[rdAddr_r];
            end
        end

        assign rdWord0[l*LANE_W +: LANE_W] = rdA_r;
        assign rdWord1[l*LANE_W +: LANE_W] = rdB_r;
    end

    // ==========================================================
    // outputs
    assign wrDone = wrDone_r;
    assign wrDoneAddr = wrDoneAddr_r;
    assign rdValid = rdValid_r;
    assign rdDoneAddr = rdDoneAddr_r;
    assign rdData0 = rdWord0;
    assign rdData1 = rdWord1;
endmodule

//--- rtl/sram_link_pkg.sv
// shared widths and burst constants for the write-port link
// assumes both ends run on one core clock; phase flag marks clock edges
package sram_link_pkg;

    // ==========================================================
    // variant widths (x36 default, others listed)
    localparam int ADDR_W_X8 = 22;
    localparam int ADDR_W_X18 = 21;
    localparam int ADDR_W_X36 = 20;
    localparam int DATA_W_X36 = 36;
    localparam int MASK_W_X36 = 4;
    localparam int NIBBLE_MASK_W = 2;

    // ==========================================================
    // burst and buffering
    localparam int BURST_WORDS = 2;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // reset values
    localparam logic SEL_IDLE_N = 1'b1;
    localparam logic PHASE_RST = 1'b1;

endpackage

//--- rtl/sram_link_if.sv
// link between memory controller end and memory device end
// assumes one core clock; kEdge high marks a positive-clock edge cycle
`timescale 1ns/100ps
interface sram_link_if #(
    parameter int ADDR_W = sram_link_pkg::ADDR_W_X36,
    parameter int DATA_W = sram_link_pkg::DATA_W_X36,
    parameter int MASK_W = sram_link_pkg::MASK_W_X36
);
    logic kEdge;
    logic writePortSelectN;
    logic readPortSelectN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [MASK_W-1:0] byteLaneWriteMaskN;

    modport ctrl (
        output kEdge,
        output writePortSelectN,
        output readPortSelectN,
        output addr,
        output data,
        output byteLaneWriteMaskN
    );

    modport dev (
        input kEdge,
        input writePortSelectN,
        input readPortSelectN,
        input addr,
        input data,
        input byteLaneWriteMaskN
    );
endinterface

//--- rtl/sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/100ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = sram_link_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    import sram_link_pkg::*;

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] rdPtr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    assign inReady = (count_r != (PW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = store[rdPtr_r];

    // ==========================================================
    // storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wrPtr_r] <= inData;
        end
    end

    // ==========================================================
    // pointers and fill level
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

//--- rtl/sram_ctrl_end.sv
// memory controller end: turns buffered write bursts and read
// requests into the time-multiplexed link sequence
// assumes the device end samples the link on the same core clock
`timescale 1ns/100ps
module sram_ctrl_end #(
    parameter int ADDR_W = sram_link_pkg::ADDR_W_X36,
    parameter int DATA_W = sram_link_pkg::DATA_W_X36,
    parameter int MASK_W = sram_link_pkg::MASK_W_X36
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // write burst request
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData0,
    input wire logic [DATA_W-1:0] wrData1,
    input wire logic [MASK_W-1:0] wrMask0N,
    input wire logic [MASK_W-1:0] wrMask1N,
    // read request
    input wire logic rdReq,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic rdBusy,
    // link
    sram_link_if.ctrl link
);
    import sram_link_pkg::*;

    localparam int EW = ADDR_W + 2 * DATA_W + 2 * MASK_W;

    logic kEdge_r;
    logic wpsN_r;
    logic rpsN_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_r;
    logic [MASK_W-1:0] mask_r;
    logic [EW-1:0] ent_r;
    logic entLive_r;
    logic rdPend_r;
    logic [ADDR_W-1:0] rdAddr_r;
    logic fifoValid;
    logic fifoTake;
    logic [EW-1:0] fifoData;

    // ==========================================================
    // write burst buffer; drained once per inverted-edge slot
    assign fifoTake = !kEdge_r;

    sync_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) i_sync_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .inValid(wrValid),
        .inReady(wrReady),
        .inData({wrAddr, wrData0, wrData1, wrMask0N, wrMask1N}),
        .outValid(fifoValid),
        .outReady(fifoTake),
        .outData(fifoData)
    );

    // ==========================================================
    // edge phase: high cycle carries the positive-clock edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            kEdge_r <= PHASE_RST;
        end else begin
            kEdge_r <= !kEdge_r;
        end
    end

    // ==========================================================
    // read request holding
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdPend_r <= 1'b0;
            rdAddr_r <= '0;
        end else if (rdReq && !rdPend_r) begin
            rdPend_r <= 1'b1;
            rdAddr_r <= rdAddr;
        end else if (!kEdge_r) begin
            rdPend_r <= 1'b0;
        end
    end

    assign rdBusy = rdPend_r;

    // ==========================================================
    // link drive
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wpsN_r <= SEL_IDLE_N;
            rpsN_r <= SEL_IDLE_N;
            addr_r <= '0;
            data_r <= '0;
            mask_r <= '1;
            ent_r <= '0;
            entLive_r <= 1'b0;
        end else if (!kEdge_r) begin
            wpsN_r <= !fifoValid;
            rpsN_r <= !rdPend_r;
            entLive_r <= fifoValid;
            ent_r <= fifoData;
            addr_r <= rdAddr_r;
            data_r <= fifoData[2*MASK_W+DATA_W +: DATA_W];
            // no burst, every lane masked off
            mask_r <= fifoValid ? fifoData[MASK_W +: MASK_W] : '1;
        end else begin
            wpsN_r <= SEL_IDLE_N;
            rpsN_r <= SEL_IDLE_N;
            addr_r <= ent_r[EW-1 -: ADDR_W];
            data_r <= ent_r[2*MASK_W +: DATA_W];
            mask_r <= entLive_r ? ent_r[0 +: MASK_W] : '1;
        end
    end

    assign link.kEdge = kEdge_r;
    assign link.writePortSelectN = wpsN_r;
    assign link.readPortSelectN = rpsN_r;
    assign link.addr = addr_r;
    assign link.data = data_r;
    assign link.byteLaneWriteMaskN = mask_r;
endmodule

//--- tb/sram_link_sva.sv
// checker for the write-port link between the two ends
// assumes the bench hands it the link signals and the core clock
`timescale 1ns/100ps
module sram_link_sva #(
    parameter int ADDR_W = sram_link_pkg::ADDR_W_X36,
    parameter int DATA_W = sram_link_pkg::DATA_W_X36,
    parameter int MASK_W = sram_link_pkg::MASK_W_X36
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link
    input wire logic kEdge,
    input wire logic writePortSelectN,
    input wire logic readPortSelectN,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data,
    input wire logic [MASK_W-1:0] byteLaneWriteMaskN
);
    import sram_link_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // edge slots and selects
    AST_EDGE_ALTERNATES: assert property (kEdge |=> !kEdge)
        else $error("link edge slot did not alternate");
    AST_EDGE_RETURNS: assert property (!kEdge |=> kEdge)
        else $error("link edge slot did not return");
    AST_RESET_IDLE: assert property ($fell(sys_rst) |-> kEdge
        && writePortSelectN && readPortSelectN && (&byteLaneWriteMaskN))
        else $error("link not idle after reset");
    AST_WRITE_SEL_K_ONLY: assert property (!kEdge
        |-> writePortSelectN)
        else $error("write select low outside positive slot");
    AST_READ_SEL_K_ONLY: assert property (!kEdge |-> readPortSelectN)
        else $error("read select low outside positive slot");

    // ==========================================================
    // lane masks when no burst, single-slot selects
    AST_IDLE_MASK_K: assert property (kEdge && writePortSelectN
        |-> &byteLaneWriteMaskN)
        else $error("lane mask active without a burst");
    AST_IDLE_MASK_KBAR: assert property (kEdge && writePortSelectN
        |=> &byteLaneWriteMaskN)
        else $error("second-word mask active without a burst");
    AST_WRITE_SEL_ONE_SLOT: assert property ($fell(writePortSelectN)
        |-> kEdge ##1 (writePortSelectN && !kEdge))
        else $error("write select not a single slot");
    AST_READ_SEL_ONE_SLOT: assert property ($fell(readPortSelectN)
        |-> kEdge ##1 (readPortSelectN && !kEdge))
        else $error("read select not a single slot");
endmodule

//--- tb/test_sram_write_port_addr_capture.sv
// self-checking bench: controller end and device end back to back
// assumes a shrunken address width so the arrays stay small
`timescale 1ns/100ps
module test_sram_write_port_addr_capture;
    import sram_link_pkg::*;
    localparam int AW = 6;
    localparam int DW = DATA_W_X36;
    localparam int MW = MASK_W_X36;
    localparam int LW = DW / MW;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wrValid = 1'b0;
    logic wrReady;
    logic [AW-1:0] wrAddr = '0;
    logic [DW-1:0] wrData0 = '0;
    logic [DW-1:0] wrData1 = '0;
    logic [MW-1:0] wrMask0N = '1;
    logic [MW-1:0] wrMask1N = '1;
    logic rdReq = 1'b0;
    logic [AW-1:0] rdAddr = '0;
    logic rdBusy, wrDone, rdValid;
    logic [AW-1:0] wrDoneAddr, rdDoneAddr;
    logic [DW-1:0] rdData0, rdData1;
    logic [DW-1:0] mem0 [64];
    logic [DW-1:0] mem1 [64];
    int n_errors = 0;
    int n_compared = 0;
    int nWrDone = 0;
    int nRdValid = 0;

    always #10 core_clk = ~core_clk;

    sram_link_if #(.ADDR_W(AW), .DATA_W(DW), .MASK_W(MW)) link ();
    sram_ctrl_end #(.ADDR_W(AW), .DATA_W(DW), .MASK_W(MW)) i_sram_ctrl_end (
        .core_clk(core_clk), .sys_rst(sys_rst), .wrValid(wrValid),
        .wrReady(wrReady), .wrAddr(wrAddr), .wrData0(wrData0),
        .wrData1(wrData1), .wrMask0N(wrMask0N), .wrMask1N(wrMask1N),
        .rdReq(rdReq), .rdAddr(rdAddr), .rdBusy(rdBusy), .link(link));
    sram_dev_end #(.ADDR_W(AW), .DATA_W(DW), .MASK_W(MW)) i_sram_dev_end (
        .core_clk(core_clk), .sys_rst(sys_rst), .link(link),
        .wrDone(wrDone), .wrDoneAddr(wrDoneAddr), .rdValid(rdValid),
        .rdDoneAddr(rdDoneAddr), .rdData0(rdData0), .rdData1(rdData1));
    sram_link_sva #(.ADDR_W(AW), .DATA_W(DW), .MASK_W(MW)) i_checker (
        .core_clk(core_clk), .sys_rst(sys_rst), .kEdge(link.kEdge),
        .writePortSelectN(link.writePortSelectN),
        .readPortSelectN(link.readPortSelectN), .addr(link.addr),
        .data(link.data), .byteLaneWriteMaskN(link.byteLaneWriteMaskN));

    always @(posedge core_clk) begin
        if (wrDone === 1'b1) nWrDone++;
        if (rdValid === 1'b1) nRdValid++;
    end

    // ==========================================================
    // reporting
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(string what);
        n_errors++;
        $display("timeout waiting for %s", what);
        stop_test();
    endtask

    // lane merge of masked write, lane 0 lowest
    function automatic logic [DW-1:0] merge(logic [DW-1:0] old,
            logic [DW-1:0] nw, logic [MW-1:0] mN);
        logic [DW-1:0] r;
        r = old;
        for (int i = 0; i < MW; i++) begin
            if (!mN[i]) r[i*LW +: LW] = nw[i*LW +: LW];
        end
        return r;
    endfunction

    // ==========================================================
    // bus tasks
    task automatic wr(int a, logic [DW-1:0] d0, logic [DW-1:0] d1,
            logic [MW-1:0] m0, logic [MW-1:0] m1);
        int t;
        int base;
        base = nWrDone;
        @(negedge core_clk);
        wrValid = 1'b1;
        wrAddr = AW'(a);
        wrData0 = d0;
        wrData1 = d1;
        wrMask0N = m0;
        wrMask1N = m1;
        t = 0;
        while (wrReady !== 1'b1 && t < 100) begin
            @(negedge core_clk);
            t++;
        end
        if (t == 100) timeout("wrReady");
        @(negedge core_clk);
        wrValid = 1'b0;
        mem0[a] = merge(mem0[a], d0, m0);
        mem1[a] = merge(mem1[a], d1, m1);
        t = 0;
        while (nWrDone == base && t < 20) begin
            @(negedge core_clk);
            t++;
        end
        if (t == 20) timeout("wrDone");
        check("wrDoneAddr", wrDoneAddr, a);
    endtask

    task automatic rd(int a);
        int t;
        int base;
        base = nRdValid;
        t = 0;
        while (rdBusy !== 1'b0 && t < 20) begin
            @(negedge core_clk);
            t++;
        end
        if (t == 20) timeout("rdBusy");
        rdReq = 1'b1;
        rdAddr = AW'(a);
        @(negedge core_clk);
        rdReq = 1'b0;
        t = 0;
        while (nRdValid == base && t < 20) begin
            @(negedge core_clk);
            t++;
        end
        if (t == 20) timeout("rdValid");
        check("rdDoneAddr", rdDoneAddr, a);
        check("rdData0", rdData0, mem0[a]);
        check("rdData1", rdData1, mem1[a]);
    endtask

    // ==========================================================
    // scenarios
    task automatic test_full();
        wr(5, 36'h123456789, 36'hfedcba987, '0, '0);
        wr(6, 36'h0a5a5a5a5, 36'h05a5a5a5a, '0, '0);
        rd(5);
        rd(6);
        $display("test_full done");
    endtask

    task automatic test_masks();
        wr(10, 36'h000000000, 36'hfffffffff, '0, '0);
        for (int i = 0; i < MW; i++) begin
            wr(10, 36'h5a5a5a5a5 ^ DW'(i), 36'h3c3c3c3c3 ^ DW'(i),
               MW'(~(1 << i)), MW'(~(8 >> i)));
            rd(10);
        end
        wr(10, 36'h111111111, 36'h222222222, '1, '1);
        rd(10);
        $display("test_masks done");
    endtask

    task automatic test_fill();
        int n;
        int t;
        int base;
        logic refused;
        n = 0;
        refused = 1'b0;
        base = nWrDone;
        for (int i = 0; i < 60 && !refused; i++) begin
            @(negedge core_clk);
            if (wrReady === 1'b1) begin
                wrValid = 1'b1;
                wrAddr = AW'(20 + n);
                wrData0 = DW'(n * 3 + 1);
                wrData1 = ~DW'(n);
                wrMask0N = '0;
                wrMask1N = '0;
                mem0[20 + n] = DW'(n * 3 + 1);
                mem1[20 + n] = ~DW'(n);
                n++;
            end else begin
                wrValid = 1'b0;
                refused = 1'b1;
            end
        end
        wrValid = 1'b0;
        check("refused", refused, 1'b1);
        check("accepted", n >= FIFO_DEPTH, 1'b1);
        t = 0;
        while (nWrDone != base + n && t < 200) begin
            @(negedge core_clk);
            t++;
        end
        if (t == 200) timeout("bursts");
        check("bursts", nWrDone - base, n);
        rd(20);
        rd(20 + n - 1);
        $display("test_fill done");
    endtask

    task automatic test_read_refuse();
        int base;
        base = nRdValid;
        @(negedge core_clk);
        rdReq = 1'b1;
        rdAddr = AW'(5);
        @(negedge core_clk);
        check("rdBusy", rdBusy, 1'b1);
        rdAddr = AW'(6);
        @(negedge core_clk);
        rdReq = 1'b0;
        repeat (12) @(negedge core_clk);
        check("reads", nRdValid - base, 1);
        check("rdDoneAddr", rdDoneAddr, 5);
        check("rdData0", rdData0, mem0[5]);
        $display("test_read_refuse done");
    endtask

    initial begin
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        test_full();
        test_masks();
        test_fill();
        test_read_refuse();
        stop_test();
    end
endmodule
